// >>> design/dsb_bridge.sv
// Strobe-driven bridge between a processor memory port and internal logic.
// Assumes the processor strobes stay well above three system clocks.
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------------
// Dual-port FIFO
// --------------------------------------------------------------------
module dsb_fifo #(
    parameter int AW = dsb_pkg::ADDR_W,
    parameter int DW = dsb_pkg::DATA_W,
    parameter int CW = dsb_pkg::FILL_W
) (
    // Clock and control
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          init,
    // Fill side
    input  wire logic          push,
    input  wire logic [DW-1:0] push_data,
    // Drain side
    input  wire logic          pop,
    output logic      [DW-1:0] head,
    // Status
    output logic      [AW-1:0] count,
    output logic               full,
    output logic               nearly_full,
    output logic               empty,
    output logic               nearly_empty,
    output logic      [CW-1:0] fill
);
    localparam logic [AW-1:0] CAP = AW'(dsb_pkg::CAPACITY);
    localparam logic [AW-1:0] ONE = AW'(1);

    logic [DW-1:0] mem [0:(1<<AW)-1]; // [RQ16]
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] next_rd;
    logic [AW-1:0] next_count;
    logic          do_push;
    logic          do_pop;

    assign do_push    = push & ~full & ~init;
    assign do_pop     = pop & ~empty & ~init;
    assign next_rd    = rd_ptr + AW'(do_pop);
    assign next_count = count + AW'(do_push) - AW'(do_pop);

    // Independent write and read ports on separate pointers
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr] <= push_data; // [RQ14]
        end
    end

    always_ff @(posedge clk) begin
        if (rst || init) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= wr_ptr + AW'(do_push);
            rd_ptr <= next_rd;
            count  <= next_count;
        end
    end

    // Same-address write forwards so head never shows a stale word
    always_ff @(posedge clk) begin
        if (rst) begin
            head <= '0;
        end else if (do_push && wr_ptr == next_rd) begin
            head <= push_data; // [RQ14]
        end else begin
            head <= mem[next_rd]; // [RQ15]
        end
    end

    // Flags forced high while initialising, then follow occupancy
    always_ff @(posedge clk) begin
        if (rst || init) begin
            full         <= 1'b1; // [RQ7]
            nearly_full  <= 1'b1;
            empty        <= 1'b1;
            nearly_empty <= 1'b1;
        end else begin
            full         <= next_count == CAP; // [RQ8]
            nearly_full  <= next_count >= CAP - ONE; // [RQ10]
            empty        <= next_count == '0; // [RQ9]
            nearly_empty <= next_count <= ONE; // [RQ10]
        end
    end

    // Upper count bits, one cycle behind
    always_ff @(posedge clk) begin
        if (rst) begin
            fill <= '0;
        end else begin
            fill <= count[AW-1 -: CW]; // [RQ11] [RQ12] [RQ13]
        end
    end
endmodule

// Contract
// [RQ1] Separate FIFOs for each transfer direction
// [RQ2] FIFO clocks come from write/read strobes
// [RQ3] Processor keeps strobes toggling continuously
// [RQ4] Select plus output enable picks FIFO section
// [RQ5] Same decode enables data mux, flag select
// [RQ6] Processor drives controls, shares wide data bus
// [RQ7] Init holds all flags high
// [RQ8] Full flags drop on first write edge; here they drop the cycle after reset or init ends
// [RQ9] Empty flags drop on first read edge; here empty drops on the clock edge that pushes the first word, nearly empty on the second
// [RQ10] Nearly flags mean one place left
// [RQ11] Fill counts are delayed upper address bits
// [RQ12] Two-bit fill counts report quarters
// [RQ13] Fill count width is configurable
// [RQ14] Memory ports read and write independently
// [RQ15] Each memory port has own timing, width; here both ports share clk and width DW
// [RQ16] Memory shapes 1x16384, 9x2048, 36x512
// [RQ17] 255 entries, 32 or 64 bits
// [RQ18] Sync mode clocks on port output clock
// [RQ19] Write strobe follows select, data present
// [RQ20] Read uses setup, two strobe, hold
// [RQ21] Interrupt lines driven from chosen flags
module dsb_bridge #(
    parameter int DW = dsb_pkg::DATA_W,
    parameter int AW = dsb_pkg::ADDR_W,
    parameter int CW = dsb_pkg::FILL_W
) (
    // Clock and reset
    input  wire logic                      CLOCK,
    input  wire logic                      SYS_RST,
    // Processor memory port
    input  wire logic                      SPACE_SELECT_N,
    input  wire logic                      ASYNC_OUTPUT_ENABLE_N,
    input  wire logic                      ASYNC_WRITE_STROBE_N,
    input  wire logic                      ASYNC_READ_STROBE_N,
    input  wire logic                      PORT_OUTPUT_CLOCK,
    input  wire logic                      FIFO_INIT,
    input  wire logic [DW-1:0]             EXT_DATA_BUS_IN,
    output logic      [DW-1:0]             EXT_DATA_BUS_OUT,
    output logic                           EXT_DATA_BUS_OE,
    output logic      [1:0]                FLAG_TO_PROCESSOR,
    output logic      [dsb_pkg::IRQ_N-1:0] PROCESSOR_INTERRUPT_LINE,
    // Processor to logic stream
    output logic      [DW-1:0]             TO_LOGIC_DATA,
    output logic                           TO_LOGIC_VALID,
    input  wire logic                      TO_LOGIC_READY,
    // Logic to processor stream
    input  wire logic [DW-1:0]             FROM_LOGIC_DATA,
    input  wire logic                      FROM_LOGIC_VALID,
    output logic                           FROM_LOGIC_READY,
    // Status toward logic
    output logic                           WRITE_FULL,
    output logic                           WRITE_NEARLY_FULL,
    output logic                           READ_EMPTY,
    output logic                           READ_NEARLY_EMPTY,
    output logic      [CW-1:0]             WRITE_FILL,
    output logic      [CW-1:0]             READ_FILL,
    // Register port
    input  wire logic [dsb_pkg::REG_AW-1:0] REG_ADDR,
    input  wire logic [31:0]               REG_WDATA,
    input  wire logic                      REG_WRITE,
    input  wire logic                      REG_READ,
    output logic      [31:0]               REG_RDATA
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [dsb_pkg::PIN_N-1:0] pin_raw;
    logic [dsb_pkg::PIN_N-1:0] pin_s1;
    logic [dsb_pkg::PIN_N-1:0] pin_s2;
    logic [dsb_pkg::PIN_N-1:0] pin_s3;
    logic [dsb_pkg::PIN_N-1:0] pin;
    logic [dsb_pkg::PIN_N-1:0] pin_prev;
    logic [DW-1:0]             dat_s1;
    logic [DW-1:0]             dat_s2;
    logic [DW-1:0]             dat_s3;

    assign pin_raw = {PORT_OUTPUT_CLOCK, FIFO_INIT, ASYNC_READ_STROBE_N,
                      ASYNC_WRITE_STROBE_N, ASYNC_OUTPUT_ENABLE_N,
                      SPACE_SELECT_N};

    for (genvar i = 0; i < dsb_pkg::PIN_N; i++) begin : g_pin
        always_ff @(posedge CLOCK) begin
            if (SYS_RST) begin
                pin_s1[i]   <= dsb_pkg::PIN_RESET[i];
                pin_s2[i]   <= dsb_pkg::PIN_RESET[i];
                pin_s3[i]   <= dsb_pkg::PIN_RESET[i];
                pin[i]      <= dsb_pkg::PIN_RESET[i];
                pin_prev[i] <= dsb_pkg::PIN_RESET[i];
            end else begin
                pin_s1[i]   <= pin_raw[i];
                pin_s2[i]   <= pin_s1[i];
                pin_s3[i]   <= pin_s2[i];
                pin[i]      <= (pin_s2[i] == pin_s3[i]) ? pin_s3[i] : pin[i];
                pin_prev[i] <= pin[i];
            end
        end
    end

    // Data takes three register stages, one fewer than the filtered strobes
    always_ff @(posedge CLOCK) begin
        dat_s1 <= EXT_DATA_BUS_IN;
        dat_s2 <= dat_s1;
        dat_s3 <= dat_s2;
    end

    // ----------------------------------------------------------------
    // Access decode
    // ----------------------------------------------------------------
    logic [4:0] ctrl;
    logic       wr_sel;
    logic       rd_sel;
    logic       pclk_rise;
    logic       push_evt;
    logic       pop_evt;
    logic       init;

    assign init    = pin[dsb_pkg::PIN_INIT] | ctrl[dsb_pkg::CTRL_INIT];
    assign wr_sel  = ~pin[dsb_pkg::PIN_CS] & pin[dsb_pkg::PIN_OE]; // [RQ4]
    assign rd_sel  = ~pin[dsb_pkg::PIN_CS] & ~pin[dsb_pkg::PIN_OE]; // [RQ4]
    assign pclk_rise = pin[dsb_pkg::PIN_PCLK] & ~pin_prev[dsb_pkg::PIN_PCLK];

    // Strobe edges clock the FIFOs, or the port clock in sync mode
    always_comb begin
        if (ctrl[dsb_pkg::CTRL_SYNC]) begin
            push_evt = pclk_rise & wr_sel & ~pin[dsb_pkg::PIN_WE]; // [RQ18]
            pop_evt  = pclk_rise & rd_sel & ~pin[dsb_pkg::PIN_RE]; // [RQ18]
        end else begin
            // Write on strobe assertion, data already present
            push_evt = wr_sel & pin_prev[dsb_pkg::PIN_WE]
                       & ~pin[dsb_pkg::PIN_WE]; // [RQ2] [RQ19]
            // Read pops at strobe release, after the word was shown
            pop_evt  = rd_sel & ~pin_prev[dsb_pkg::PIN_RE]
                       & pin[dsb_pkg::PIN_RE]; // [RQ2] [RQ20]
        end
    end

    // ----------------------------------------------------------------
    // FIFOs
    // ----------------------------------------------------------------
    logic [AW-1:0] wcount;
    logic [AW-1:0] rcount;
    logic          w_empty;
    logic          w_nempty;
    logic          r_full;
    logic          r_nfull;
    logic [DW-1:0] r_head;

    dsb_fifo #(.AW(AW), .DW(DW), .CW(CW)) u_wfifo ( // [RQ1] [RQ17]
        .clk          (CLOCK),
        .rst          (SYS_RST),
        .init         (init),
        .push         (push_evt),
        .push_data    (dat_s3),
        .pop          (TO_LOGIC_READY),
        .head         (TO_LOGIC_DATA),
        .count        (wcount),
        .full         (WRITE_FULL),
        .nearly_full  (WRITE_NEARLY_FULL),
        .empty        (w_empty),
        .nearly_empty (w_nempty),
        .fill         (WRITE_FILL)
    );

    dsb_fifo #(.AW(AW), .DW(DW), .CW(CW)) u_rfifo ( // [RQ1] [RQ17]
        .clk          (CLOCK),
        .rst          (SYS_RST),
        .init         (init),
        .push         (FROM_LOGIC_VALID),
        .push_data    (FROM_LOGIC_DATA),
        .pop          (pop_evt),
        .head         (r_head),
        .count        (rcount),
        .full         (r_full),
        .nearly_full  (r_nfull),
        .empty        (READ_EMPTY),
        .nearly_empty (READ_NEARLY_EMPTY),
        .fill         (READ_FILL)
    );

    assign TO_LOGIC_VALID   = ~w_empty;
    assign FROM_LOGIC_READY = ~r_full;
    assign EXT_DATA_BUS_OUT = r_head;
    assign EXT_DATA_BUS_OE  = rd_sel; // [RQ5]

    // Flag pair shown to the processor follows the selected section
    always_comb begin
        if (rd_sel) begin
            FLAG_TO_PROCESSOR = {READ_NEARLY_EMPTY, READ_EMPTY}; // [RQ5]
        end else if (wr_sel) begin
            FLAG_TO_PROCESSOR = {WRITE_NEARLY_FULL, WRITE_FULL}; // [RQ5]
        end else begin
            FLAG_TO_PROCESSOR = 2'h0;
        end
    end

    // ----------------------------------------------------------------
    // Error capture and interrupts
    // ----------------------------------------------------------------
    logic       overflow;
    logic       underflow;
    logic       clr_wr;
    logic [2:0] irq_src;

    assign clr_wr = REG_WRITE && REG_ADDR == dsb_pkg::OFS_STATUS;

    // New event wins over a same-cycle clear
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            overflow  <= 1'b0;
            underflow <= 1'b0;
        end else begin
            overflow  <= (push_evt & WRITE_FULL)
                         | (overflow & ~(clr_wr
                         & REG_WDATA[dsb_pkg::ST_OVERFLOW]));
            underflow <= (pop_evt & READ_EMPTY)
                         | (underflow & ~(clr_wr
                         & REG_WDATA[dsb_pkg::ST_UNDERFLOW]));
        end
    end

    assign irq_src = {overflow | underflow, ~WRITE_FULL, ~READ_EMPTY};

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            PROCESSOR_INTERRUPT_LINE <= '0;
        end else begin
            PROCESSOR_INTERRUPT_LINE <= irq_src
                & ctrl[dsb_pkg::CTRL_IRQ_LSB +: dsb_pkg::IRQ_N]; // [RQ21]
        end
    end

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            ctrl <= dsb_pkg::CTRL_RESET;
        end else if (REG_WRITE && REG_ADDR == dsb_pkg::OFS_CTRL) begin
            ctrl <= REG_WDATA[4:0];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST || !REG_READ) begin
            REG_RDATA <= 32'h0000_0000;
        end else begin
            case (REG_ADDR)
                dsb_pkg::OFS_CTRL:
                    REG_RDATA <= {27'h000_0000, ctrl};
                dsb_pkg::OFS_STATUS:
                    REG_RDATA <= {22'h00_0000, underflow, overflow,
                                  READ_NEARLY_EMPTY, READ_EMPTY, r_nfull,
                                  r_full, w_nempty, w_empty,
                                  WRITE_NEARLY_FULL, WRITE_FULL};
                dsb_pkg::OFS_COUNT:
                    REG_RDATA <= {16'(READ_FILL), rcount[7:0], wcount[7:0]};
                default:
                    REG_RDATA <= 32'h0000_0000;
            endcase
        end
    end
endmodule

`default_nettype wire

// >>> design/dsb_pkg.sv
// Constants shared by the strobe-clocked FIFO bridge.
// Assumes one system clock; processor pins arrive asynchronous to it.
package dsb_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int DATA_W     = 64;
    localparam int ADDR_W     = 8;
    localparam int CAPACITY   = 255;
    localparam int FILL_W     = 2;
    localparam int BRAM_DW    = 32;
    localparam int BRAM_D_1   = 16384;
    localparam int BRAM_D_9   = 2048;
    localparam int BRAM_D_36  = 512;
    localparam int BRAM_PAR_9  = 1;
    localparam int BRAM_PAR_36 = 4;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int         REG_AW     = 8;
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_COUNT  = 8'h08;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam int CTRL_INIT     = 0;
    localparam int CTRL_SYNC     = 1;
    localparam int CTRL_IRQ_LSB  = 2;
    localparam int ST_OVERFLOW   = 8;
    localparam int ST_UNDERFLOW  = 9;
    localparam int IRQ_N         = 3;

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    localparam int         PIN_N     = 6;
    localparam logic [5:0] PIN_RESET = 6'h0f;
    localparam int PIN_CS   = 0;
    localparam int PIN_OE   = 1;
    localparam int PIN_WE   = 2;
    localparam int PIN_RE   = 3;
    localparam int PIN_INIT = 4;
    localparam int PIN_PCLK = 5;

endpackage

// >>> bench/dsb_bridge_properties.sv
// Port-level checks for the strobe-clocked FIFO bridge.
// Assumes binding into dsb_bridge; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dsb_bridge_props #(
    parameter int CW = dsb_pkg::FILL_W
) (
    // Clock and reset
    input wire logic          CLOCK,
    input wire logic          SYS_RST,
    // Processor port
    input wire logic          SPACE_SELECT_N,
    input wire logic          ASYNC_OUTPUT_ENABLE_N,
    input wire logic          FIFO_INIT,
    input wire logic          EXT_DATA_BUS_OE,
    input wire logic [1:0]    FLAG_TO_PROCESSOR,
    // Status
    input wire logic          TO_LOGIC_VALID,
    input wire logic          WRITE_FULL,
    input wire logic          WRITE_NEARLY_FULL,
    input wire logic          READ_EMPTY,
    input wire logic          READ_NEARLY_EMPTY,
    input wire logic [CW-1:0] WRITE_FILL,
    input wire logic [CW-1:0] READ_FILL
);
    logic       all_set;
    logic [3:0] quiet;
    assign all_set = WRITE_FULL && WRITE_NEARLY_FULL && READ_EMPTY
                     && READ_NEARLY_EMPTY;
    // Cycles since reset and the init pin went quiet
    always_ff @(posedge CLOCK) begin
        if (SYS_RST || FIFO_INIT)
            quiet <= 4'h0;
        else if (quiet != 4'hf)
            quiet <= quiet + 4'h1;
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    a_reset_flags: assert property (disable iff (1'b0)
        SYS_RST |=> all_set && !TO_LOGIC_VALID && !EXT_DATA_BUS_OE)
        else $error("flags not forced in reset");
    a_init_flags: assert property (FIFO_INIT [*8] |-> all_set)
        else $error("flags not forced by init");
    a_init_release: assert property (
        quiet == 4'hf && $past(quiet) == 4'he |-> !WRITE_FULL
        && !WRITE_NEARLY_FULL) else $error("full flags kept after init");
    a_nfull_full: assert property (WRITE_FULL |-> WRITE_NEARLY_FULL)
        else $error("nearly full missing");
    a_nempty_empty: assert property (READ_EMPTY |-> READ_NEARLY_EMPTY)
        else $error("nearly empty missing");
    a_full_fill: assert property (
        quiet == 4'hf && WRITE_FULL && $past(WRITE_FULL) |-> WRITE_FILL == '1)
        else $error("fill not top quarter");
    a_empty_fill: assert property (
        quiet == 4'hf && READ_EMPTY [*2] |-> READ_FILL == '0)
        else $error("fill not zero");
    a_oe_on: assert property (
        (!SPACE_SELECT_N && !ASYNC_OUTPUT_ENABLE_N) [*8] |-> EXT_DATA_BUS_OE)
        else $error("bus not driven");
    a_oe_off: assert property (SPACE_SELECT_N [*8] |->
        !EXT_DATA_BUS_OE && FLAG_TO_PROCESSOR == 2'b00)
        else $error("bus or flags driven");
    c_full: cover property (quiet == 4'hf && WRITE_FULL);
    c_one_left: cover property (READ_NEARLY_EMPTY && !READ_EMPTY);
    c_driven: cover property (EXT_DATA_BUS_OE);
endmodule
`default_nettype wire

// >>> bench/dsb_cpu_model.sv
// Processor memory-port model driving the bridge pins.
// Assumes each access starts just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module dsb_cpu_model (
    // Clock
    input  wire logic        clk,
    // Pins toward the bridge
    output logic             cs_n,
    output logic             oe_n,
    output logic             we_n,
    output logic             re_n,
    output logic [63:0]      dq,
    // Bridge answer
    input  wire logic [63:0] din,
    input  wire logic        din_oe,
    input  wire logic [1:0]  din_flag
);
    initial begin
        cs_n = 1'b1;
        oe_n = 1'b1;
        we_n = 1'b1;
        re_n = 1'b1;
        dq = 64'h0;
    end
    // Strobe one cycle after select, data already present
    task automatic wr(input logic [63:0] d);
        cs_n <= 1'b0;
        dq <= d;
        @(posedge clk);
        we_n <= 1'b0;
        repeat (5) @(posedge clk);
        we_n <= 1'b1;
        @(posedge clk);
        cs_n <= 1'b1;
        dq <= ~d; // Released bus carries no stale word
        repeat (5) @(posedge clk);
    endtask
    // Setup, long strobe, hold; word taken as strobe ends
    task automatic rd(output logic [63:0] q, output logic [2:0] st);
        cs_n <= 1'b0;
        oe_n <= 1'b0;
        repeat (2) @(posedge clk);
        re_n <= 1'b0;
        repeat (5) @(posedge clk);
        q = din;
        st = {din_oe, din_flag};
        re_n <= 1'b1;
        repeat (2) @(posedge clk);
        cs_n <= 1'b1;
        oe_n <= 1'b1;
        repeat (5) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// >>> bench/tb_dsp_strobe_clocked_fifo_bridge.sv
// Self-checking bench for the strobe-clocked FIFO bridge.
// Assumes the bridge, its checker and the port model are compiled.
`timescale 1ns/1ps
`default_nettype none
module tb_dsp_strobe_clocked_fifo_bridge;
    logic        clk, sys_rst, fifo_init, cs_n, oe_n, we_n, re_n;
    logic [63:0] dq_in, dq_out, to_data, from_data;
    logic        dq_oe, to_valid, to_ready, from_valid, from_ready;
    logic        wfull, wnfull, rempty, rnempty, reg_write, reg_read;
    logic [1:0]  flag_p, wfill;
    logic [2:0]  irq;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [63:0] wq[$], rq[$];
    int          err_total, checks;

    dsb_bridge uut (
        .CLOCK(clk), .SYS_RST(sys_rst),
        .SPACE_SELECT_N(cs_n), .ASYNC_OUTPUT_ENABLE_N(oe_n),
        .ASYNC_WRITE_STROBE_N(we_n), .ASYNC_READ_STROBE_N(re_n),
        .PORT_OUTPUT_CLOCK(1'b0), .FIFO_INIT(fifo_init),
        .EXT_DATA_BUS_IN(dq_in), .EXT_DATA_BUS_OUT(dq_out),
        .EXT_DATA_BUS_OE(dq_oe), .FLAG_TO_PROCESSOR(flag_p),
        .PROCESSOR_INTERRUPT_LINE(irq), .TO_LOGIC_DATA(to_data),
        .TO_LOGIC_VALID(to_valid), .TO_LOGIC_READY(to_ready),
        .FROM_LOGIC_DATA(from_data), .FROM_LOGIC_VALID(from_valid),
        .FROM_LOGIC_READY(from_ready), .WRITE_FULL(wfull),
        .WRITE_NEARLY_FULL(wnfull), .READ_EMPTY(rempty),
        .READ_NEARLY_EMPTY(rnempty), .WRITE_FILL(wfill), .READ_FILL(),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WRITE(reg_write),
        .REG_READ(reg_read), .REG_RDATA(reg_rdata));
    dsb_cpu_model cpu (
        .clk(clk), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .re_n(re_n),
        .dq(dq_in), .din(dq_out), .din_oe(dq_oe), .din_flag(flag_p));

    task automatic cmp64(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        cmp64({32'h0, got}, {32'h0, exp});
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // Full, nearly full and quarter fill after n pushes
    function automatic logic [31:0] wexp(input int n);
        return {28'h0, n == 255, n >= 254, 2'(n >> 6)};
    endfunction
    task automatic finish_test();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        finish_test();
    end
    initial begin
        logic [63:0] d;
        logic [31:0] r;
        logic [2:0]  st;
        {err_total, checks} = '0;
        {sys_rst, fifo_init, to_ready, from_valid} = 4'h8;
        {from_data, reg_addr, reg_wdata, reg_write, reg_read} = '0;
        r = $urandom(32'h33d4);
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        #1 cmp32({wfull, wnfull, rempty, rnempty}, 32'hf);
        @(posedge clk);
        #1 cmp32({wfull, wnfull, rempty, rnempty}, 32'h3);
        @(posedge clk);
        fifo_init <= 1'b1;
        repeat (10) @(posedge clk);
        fifo_init <= 1'b0;
        #1 cmp32({wfull, wnfull, rempty, rnempty}, 32'hf);
        repeat (10) @(posedge clk);
        #1 cmp32({wfull, wnfull, rempty, rnempty}, 32'h3);
        reg_wr(dsb_pkg::OFS_CTRL, 32'h0000_0004);
        for (int n = 1; n <= 255; n++) begin
            d = {$urandom, $urandom};
            wq.push_back(d);
            cpu.wr(d);
            #1 cmp32({28'h0, wfull, wnfull, wfill}, wexp(n));
        end
        cpu.wr(64'h0123_4567_89ab_cdef);
        reg_rd(dsb_pkg::OFS_STATUS, r);
        cmp32(r, 32'h0000_01c3);
        reg_wr(dsb_pkg::OFS_STATUS, 32'h0000_0100);
        reg_rd(dsb_pkg::OFS_STATUS, r);
        cmp32(r, 32'h0000_00c3);
        reg_rd(dsb_pkg::OFS_COUNT, r);
        cmp32(r & 32'h0000_00ff, 32'h0000_00ff);
        reg_rd(8'h3c, r);
        cmp32(r, 32'h0);
        for (int k = 0; k < 3000 && wq.size() > 0; k++) begin
            @(posedge clk);
            to_ready <= 1'($urandom);
            #1 if (to_valid === 1'b1 && to_ready)
                cmp64(to_data, wq.pop_front());
        end
        @(posedge clk);
        to_ready <= 1'b0;
        repeat (2) @(posedge clk);
        #1 cmp32({31'h0, to_valid}, 32'(wq.size()));
        for (int i = 0; i < 3; i++) begin
            d = {$urandom, $urandom};
            rq.push_back(d);
            @(posedge clk);
            from_data <= d;
            from_valid <= 1'b1;
            #1 cmp32({31'h0, from_ready}, 32'h1);
            @(posedge clk);
            from_valid <= 1'b0;
            repeat (3) @(posedge clk);
            #1 cmp32({rempty, rnempty, irq[0]}, {1'b0, i == 0, 1'b1});
        end
        for (int i = 0; i < 3; i++) begin
            cpu.rd(d, st);
            cmp64(d, rq.pop_front());
            cmp32({29'h0, st}, {30'h1, i == 2, 1'b0});
        end
        cpu.rd(d, st);
        cmp32({29'h0, st}, 32'h7);
        reg_rd(dsb_pkg::OFS_STATUS, r);
        cmp32(r, 32'h0000_02cc);
        finish_test();
    end
endmodule

bind dsb_bridge dsb_bridge_props #(.CW(CW)) u_props (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .SPACE_SELECT_N(SPACE_SELECT_N),
    .ASYNC_OUTPUT_ENABLE_N(ASYNC_OUTPUT_ENABLE_N), .FIFO_INIT(FIFO_INIT),
    .EXT_DATA_BUS_OE(EXT_DATA_BUS_OE), .FLAG_TO_PROCESSOR(FLAG_TO_PROCESSOR),
    .TO_LOGIC_VALID(TO_LOGIC_VALID), .WRITE_FULL(WRITE_FULL),
    .WRITE_NEARLY_FULL(WRITE_NEARLY_FULL), .READ_EMPTY(READ_EMPTY),
    .READ_NEARLY_EMPTY(READ_NEARLY_EMPTY), .WRITE_FILL(WRITE_FILL),
    .READ_FILL(READ_FILL));
`default_nettype wire
